// ==== hw/tsr_if.sv ====
// two-wire bus between the bus master and the sensor slave
`timescale 1ns/1ps
interface tsr_if;
  logic scl_oe_host;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic scl;
  logic sda;

  // open-drain lines with pull-ups: low whenever any party drives
  assign scl = ~scl_oe_host;
  assign sda = ~(sda_oe_host | sda_oe_dev);

  modport host (output scl_oe_host, output sda_oe_host, input scl, input sda);
  modport dev  (output sda_oe_dev, input scl, input sda);
endinterface : tsr_if

// ==== hw/tsr_master.sv ====
// two-wire bus master that reads and writes the sensor's registers
`timescale 1ns/1ps
`include "tsr_params.svh"
module tsr_master
  import tsr_pkg::*;
#(
  parameter logic [6:0]  SLAVE_ADDR     = `TSR_SLAVE_ADDR,
  parameter int unsigned SCL_HZ         = `TSR_SCL_HZ,
  parameter int unsigned HOLDOFF_CYCLES = (`TSR_CLK_HZ / 1000000) * `TSR_HOLDOFF_US
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // two-wire bus
  tsr_if.host             bus,
  // command port
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic       cmd_has_data,
  input  wire logic [7:0] cmd_ptr,
  input  wire logic [7:0] cmd_data,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic            rsp_nack,
  output logic [7:0]      rsp_data,
  output logic            holdoff_active
);

  // quarter of an scl period, rounded up so the bus never exceeds its rate
  localparam int unsigned QTR = (`TSR_CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);

  logic [15:0] qtr_cnt;
  logic        qtick;
  always_ff @(posedge clock) begin
    if (!rst_n || qtick) begin
      qtr_cnt <= 16'h0000;
    end else begin
      qtr_cnt <= qtr_cnt + 16'h0001;
    end
  end
  assign qtick = qtr_cnt == 16'(QTR - 1);

  logic [2:0] sda_sync;
  logic       sda_q;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sda_sync <= 3'h7;
      sda_q    <= 1'b1;
    end else begin
      sda_sync <= {sda_sync[1:0], bus.sda};
      if (sda_sync[1] == sda_sync[2]) begin
        sda_q <= sda_sync[2];
      end
    end
  end

  // one-shot commands wait out the holdoff after shutdown is written
  logic [31:0] hold_cnt;
  logic        is_oneshot;
  assign is_oneshot = !cmd_read && cmd_has_data && cmd_ptr == `TSR_PTR_ONESHOT;

  tsr_master_state_e state;
  tsr_step_e         step;
  logic [1:0]        qph;
  logic [3:0]        bit_idx;
  logic [7:0]        sh;
  logic              rd, has_data, nack;
  logic [7:0]        ptr_q, data_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_cnt <= 32'h0;
    end else if (state == TSR_M_DONE && !rd && has_data && ptr_q == `TSR_PTR_CFG_WR
                 && data_q[`TSR_CFG_SD_BIT]) begin
      hold_cnt <= HOLDOFF_CYCLES;
    end else if (hold_cnt != 32'h0) begin
      hold_cnt <= hold_cnt - 32'h1;
    end
  end

  function automatic tsr_step_e next_step(input tsr_step_e s, input logic r, input logic d);
    case (s)
      TSR_Q_ADDR_W: next_step = TSR_Q_PTR;
      TSR_Q_PTR:    next_step = r ? TSR_Q_RSTART : (d ? TSR_Q_DATA : TSR_Q_END);
      TSR_Q_ADDR_R: next_step = TSR_Q_READ;
      default:      next_step = TSR_Q_END;
    endcase
  endfunction : next_step

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state           <= TSR_M_IDLE;
      step            <= TSR_Q_ADDR_W;
      qph             <= 2'h0;
      bit_idx         <= 4'h0;
      sh              <= 8'h00;
      rd              <= 1'b0;
      has_data        <= 1'b0;
      nack            <= 1'b0;
      ptr_q           <= 8'h00;
      data_q          <= 8'h00;
      cmd_ready       <= 1'b0;
      rsp_valid       <= 1'b0;
      rsp_nack        <= 1'b0;
      rsp_data        <= 8'h00;
      bus.scl_oe_host <= 1'b0;
      bus.sda_oe_host <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        TSR_M_IDLE: begin
          cmd_ready <= !(hold_cnt != 32'h0 && is_oneshot);
          if (cmd_valid && cmd_ready && !(hold_cnt != 32'h0 && is_oneshot)) begin
            cmd_ready <= 1'b0;
            rd        <= cmd_read;
            has_data  <= cmd_has_data;
            ptr_q     <= cmd_ptr;
            data_q    <= cmd_data;
            nack      <= 1'b0;
            step      <= TSR_Q_ADDR_W;
            qph       <= 2'h0;
            state     <= TSR_M_START;
          end
        end
        TSR_M_START: if (qtick) begin
          qph <= qph + 2'h1;
          case (qph)
            2'h0: bus.sda_oe_host <= 1'b0;
            2'h1: bus.scl_oe_host <= 1'b0;
            2'h2: bus.sda_oe_host <= 1'b1;
            default: begin
              bus.scl_oe_host <= 1'b1;
              sh      <= (step == TSR_Q_RSTART) ? {SLAVE_ADDR, 1'b1} : {SLAVE_ADDR, 1'b0};
              step    <= (step == TSR_Q_RSTART) ? TSR_Q_ADDR_R : TSR_Q_ADDR_W;
              bit_idx <= 4'h0;
              state   <= TSR_M_BYTE;
            end
          endcase
        end
        TSR_M_BYTE: if (qtick) begin
          qph <= qph + 2'h1;
          case (qph)
            // data moves only while scl is low; ack bit and read bits are released
            2'h0: bus.sda_oe_host <= bit_idx != 4'h8 && step != TSR_Q_READ
                                     && !sh[7];
            2'h1: bus.scl_oe_host <= 1'b0;
            2'h2: begin
              if (bit_idx == 4'h8) begin
                if (step != TSR_Q_READ && sda_q) begin
                  nack <= 1'b1;
                end
              end else begin
                sh <= {sh[6:0], sda_q};
              end
            end
            default: begin
              bus.scl_oe_host <= 1'b1;
              bit_idx         <= bit_idx + 4'h1;
              if (bit_idx == 4'h8) begin
                bit_idx <= 4'h0;
                if (step == TSR_Q_READ) begin
                  rsp_data <= sh;
                end
                if (nack || next_step(step, rd, has_data) == TSR_Q_END) begin
                  state <= TSR_M_STOP;
                end else if (next_step(step, rd, has_data) == TSR_Q_RSTART) begin
                  step  <= TSR_Q_RSTART;
                  state <= TSR_M_START;
                end else begin
                  step <= next_step(step, rd, has_data);
                  sh   <= (step == TSR_Q_ADDR_W) ? ptr_q : data_q;
                end
              end
            end
          endcase
        end
        TSR_M_STOP: if (qtick) begin
          qph <= qph + 2'h1;
          case (qph)
            2'h0: bus.sda_oe_host <= 1'b1;
            2'h1: bus.scl_oe_host <= 1'b0;
            2'h2: bus.sda_oe_host <= 1'b0;
            default: state <= TSR_M_DONE;
          endcase
        end
        TSR_M_DONE: begin
          rsp_valid <= 1'b1;
          rsp_nack  <= nack;
          state     <= TSR_M_IDLE;
        end
        default: state <= TSR_M_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      holdoff_active <= 1'b0;
    end else begin
      holdoff_active <= hold_cnt != 32'h0;
    end
  end

endmodule : tsr_master

// ==== hw/tsr_params.svh ====
// constants of the temperature readout serial slave and its bus master
// Operation
// - each channel result is whole byte plus fraction byte
// - remote fraction always sixteenth degree steps
// - local fraction step follows two resolution bits
// - fraction sits in bits 7..4, low nibble zero
// - coarser local steps zero the unused fraction bits
// - range change leaves limits, host rewrites them
// - shutdown finishes current conversion then stops
// - shutdown clear means conversions repeat continuously
// - write to 0fh in shutdown starts one conversion
// - one-shot data byte is discarded
// - host waits 200 us after shutdown before one-shot
// - device is slave only, never drives clock
// - bus works from 1 kHz up to 400 kHz
// - every byte shifted most significant bit first
// - master makes clock, start and stop
// - start and stop seen as sda edges, scl high
// - address byte is seven bits plus direction
// - matched slave holds sda low in ninth clock
// - eight data clocks plus ack, sda moves at scl low
// - any byte count, receiver acknowledges each byte
// - master ends read with not-acknowledge
// - reads use last written pointer, pointer retained
`ifndef TSR_PARAMS_SVH
`define TSR_PARAMS_SVH

`define TSR_CLK_HZ        100000000
`define TSR_SCL_HZ        400000
`define TSR_SCL_MIN_HZ    1000
`define TSR_HOLDOFF_US    200
`define TSR_SLAVE_ADDR    7'h4c

`define TSR_PTR_LOCAL_HI  8'h00
`define TSR_PTR_REMOTE_HI 8'h01
`define TSR_PTR_CFG_RD    8'h03
`define TSR_PTR_CFG_WR    8'h09
`define TSR_PTR_ONESHOT   8'h0f
`define TSR_PTR_REMOTE_LO 8'h10
`define TSR_PTR_LOCAL_LO  8'h15
`define TSR_PTR_RES       8'h1a

`define TSR_CFG_SD_BIT    6
`define TSR_CFG_RANGE_BIT 2
`define TSR_CFG_WMASK     8'h44
`define TSR_CFG_RESET     8'h00
`define TSR_RES_RESET     2'h3

`define TSR_MASK_HALF     8'h80
`define TSR_MASK_QUARTER  8'hc0
`define TSR_MASK_EIGHTH   8'he0
`define TSR_MASK_SIXTEENTH 8'hf0

`endif

// ==== hw/tsr_pkg.sv ====
// types shared by both ends of the temperature readout link
package tsr_pkg;
  typedef enum logic [2:0] {
    TSR_S_IDLE    = 3'b000,
    TSR_S_ADDR    = 3'b001,
    TSR_S_ADDR_ACK= 3'b010,
    TSR_S_WR      = 3'b011,
    TSR_S_WR_ACK  = 3'b100,
    TSR_S_RD      = 3'b101,
    TSR_S_RD_ACK  = 3'b110
  } tsr_slave_state_e;

  typedef enum logic [1:0] {
    TSR_C_IDLE = 2'b00,
    TSR_C_RUN  = 2'b01
  } tsr_conv_state_e;

  typedef enum logic [2:0] {
    TSR_M_IDLE  = 3'b000,
    TSR_M_START = 3'b001,
    TSR_M_BYTE  = 3'b010,
    TSR_M_STOP  = 3'b011,
    TSR_M_DONE  = 3'b100
  } tsr_master_state_e;

  typedef enum logic [2:0] {
    TSR_Q_ADDR_W = 3'b000,
    TSR_Q_PTR    = 3'b001,
    TSR_Q_DATA   = 3'b010,
    TSR_Q_RSTART = 3'b011,
    TSR_Q_ADDR_R = 3'b100,
    TSR_Q_READ   = 3'b101,
    TSR_Q_END    = 3'b110
  } tsr_step_e;
endpackage : tsr_pkg

// ==== hw/tsr_slave.sv ====
// sensor readout slave: two-wire register access, result formatting, conversion control
`timescale 1ns/1ps
`include "tsr_params.svh"
module tsr_slave
  import tsr_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = `TSR_SLAVE_ADDR
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // two-wire bus
  tsr_if.dev              bus,
  // conversion front end
  input  wire logic [7:0] local_whole,
  input  wire logic [3:0] local_frac,
  input  wire logic [7:0] remote_whole,
  input  wire logic [3:0] remote_frac,
  input  wire logic       conv_done,
  output logic            conv_start,
  output logic            conv_busy,
  output logic            range_ext,
  output logic            shutdown_bit
);

  // three-stage synchronisers; a level counts once stages two and three agree
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic       scl_q;
  logic       sda_q;
  logic       scl_prev;
  logic       sda_prev;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], bus.scl};
      sda_sync <= {sda_sync[1:0], bus.sda};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      if (scl_sync[1] == scl_sync[2]) begin
        scl_q <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_q <= sda_sync[2];
      end
      scl_prev <= scl_q;
      sda_prev <= sda_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl_rise   = scl_q & ~scl_prev;
  assign scl_fall   = ~scl_q & scl_prev;
  assign start_seen = scl_q & scl_prev & sda_prev & ~sda_q;
  assign stop_seen  = scl_q & scl_prev & ~sda_prev & sda_q;

  // registers
  logic [7:0] pointer;
  logic [7:0] config_reg;
  logic [1:0] local_res;
  logic [7:0] local_hi;
  logic [7:0] local_lo;
  logic [7:0] remote_hi;
  logic [7:0] remote_lo;

  function automatic logic [7:0] frac_mask(input logic [1:0] res);
    case (res)
      2'h0:    frac_mask = `TSR_MASK_HALF;
      2'h1:    frac_mask = `TSR_MASK_QUARTER;
      2'h2:    frac_mask = `TSR_MASK_EIGHTH;
      default: frac_mask = `TSR_MASK_SIXTEENTH;
    endcase
  endfunction : frac_mask

  function automatic logic [7:0] read_mux(input logic [7:0] ptr);
    case (ptr)
      `TSR_PTR_LOCAL_HI:  read_mux = local_hi;
      `TSR_PTR_REMOTE_HI: read_mux = remote_hi;
      `TSR_PTR_CFG_RD:    read_mux = config_reg;
      `TSR_PTR_CFG_WR:    read_mux = config_reg;
      `TSR_PTR_REMOTE_LO: read_mux = remote_lo;
      `TSR_PTR_LOCAL_LO:  read_mux = local_lo;
      `TSR_PTR_RES:       read_mux = {6'h00, local_res};
      default:            read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // register under the pointer, so its top bit can go out at the start of a repeated byte
  logic [7:0] sel_word;
  always_comb begin
    sel_word = read_mux(pointer);
  end

  // bus slave state
  tsr_slave_state_e state;
  logic [3:0]       bit_cnt;
  logic [7:0]       rx_sr;
  logic [7:0]       tx_sr;
  logic             ptr_phase;
  logic             wr_strobe;
  logic [7:0]       wr_ptr;
  logic [7:0]       wr_data;

  // the slave only ever pulls sda; scl is never driven
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state      <= TSR_S_IDLE;
      bit_cnt    <= 4'h0;
      rx_sr      <= 8'h00;
      tx_sr      <= 8'h00;
      ptr_phase  <= 1'b0;
      wr_strobe  <= 1'b0;
      wr_ptr     <= 8'h00;
      wr_data    <= 8'h00;
      bus.sda_oe_dev <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      if (start_seen) begin
        state          <= TSR_S_ADDR;
        bit_cnt        <= 4'h0;
        ptr_phase      <= 1'b1;
        bus.sda_oe_dev <= 1'b0;
      end else if (stop_seen) begin
        state          <= TSR_S_IDLE;
        bus.sda_oe_dev <= 1'b0;
      end else begin
        case (state)
          TSR_S_ADDR, TSR_S_WR: begin
            if (scl_rise) begin
              rx_sr   <= {rx_sr[6:0], sda_q};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              if (state == TSR_S_ADDR) begin
                if (rx_sr[7:1] == SLAVE_ADDR) begin
                  bus.sda_oe_dev <= 1'b1;
                  state          <= TSR_S_ADDR_ACK;
                  tx_sr          <= read_mux(pointer);
                  ptr_phase      <= ~rx_sr[0];
                end else begin
                  state <= TSR_S_IDLE;
                end
              end else begin
                // first byte of a write sets the pointer, later ones store data
                if (ptr_phase) begin
                  wr_ptr <= rx_sr;
                end else begin
                  wr_strobe <= 1'b1;
                  wr_data   <= rx_sr;
                end
                ptr_phase      <= 1'b0;
                bus.sda_oe_dev <= 1'b1;
                state          <= TSR_S_WR_ACK;
              end
            end
          end
          TSR_S_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (!ptr_phase && rx_sr[0]) begin
                state          <= TSR_S_RD;
                bus.sda_oe_dev <= ~tx_sr[7];
              end else begin
                state          <= TSR_S_WR;
                bus.sda_oe_dev <= 1'b0;
              end
            end
          end
          TSR_S_WR_ACK: begin
            if (scl_fall) begin
              bit_cnt        <= 4'h0;
              state          <= TSR_S_WR;
              bus.sda_oe_dev <= 1'b0;
            end
          end
          TSR_S_RD: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                bus.sda_oe_dev <= 1'b0;
                state          <= TSR_S_RD_ACK;
              end else begin
                tx_sr          <= {tx_sr[6:0], 1'b0};
                bus.sda_oe_dev <= ~tx_sr[6];
              end
            end
          end
          TSR_S_RD_ACK: begin
            if (scl_rise && sda_q) begin
              state <= TSR_S_IDLE;
            end else if (scl_fall) begin
              // master acked: resend the selected register
              tx_sr          <= read_mux(pointer);
              bus.sda_oe_dev <= ~sel_word[7];
              bit_cnt        <= 4'h0;
              state          <= TSR_S_RD;
            end
          end
          default: begin
            bus.sda_oe_dev <= 1'b0;
          end
        endcase
      end
    end
  end

  // pointer is kept across reads until the next write sets it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pointer <= `TSR_PTR_LOCAL_HI;
    end else if (state == TSR_S_WR_ACK && scl_fall && wr_ptr != pointer) begin
      pointer <= wr_ptr;
    end
  end

  // configuration writes; limits live elsewhere and are never reformatted here
  logic oneshot_wr;
  assign oneshot_wr = wr_strobe && pointer == `TSR_PTR_ONESHOT;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      config_reg <= `TSR_CFG_RESET;
      local_res  <= `TSR_RES_RESET;
    end else if (wr_strobe) begin
      if (pointer == `TSR_PTR_CFG_WR) begin
        config_reg <= wr_data & `TSR_CFG_WMASK;
      end
      if (pointer == `TSR_PTR_RES) begin
        local_res <= wr_data[1:0];
      end
    end
  end

  // conversion control
  tsr_conv_state_e conv_state;
  logic            oneshot_pend;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      conv_state <= TSR_C_IDLE;
      conv_start <= 1'b0;
      conv_busy  <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      case (conv_state)
        TSR_C_IDLE: begin
          // shutdown is only looked at between conversions
          if (!config_reg[`TSR_CFG_SD_BIT] || oneshot_pend) begin
            conv_state <= TSR_C_RUN;
            conv_start <= 1'b1;
            conv_busy  <= 1'b1;
          end
        end
        TSR_C_RUN: begin
          if (conv_done) begin
            conv_state <= TSR_C_IDLE;
            conv_busy  <= 1'b0;
          end
        end
        default: begin
          conv_state <= TSR_C_IDLE;
          conv_busy  <= 1'b0;
        end
      endcase
    end
  end

  // a trigger outside shutdown is acked and dropped; a new trigger beats the clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      oneshot_pend <= 1'b0;
    end else begin
      if (conv_state == TSR_C_IDLE) begin
        oneshot_pend <= 1'b0;
      end
      if (oneshot_wr && config_reg[`TSR_CFG_SD_BIT]) begin
        oneshot_pend <= 1'b1;
      end
    end
  end

  // result capture: fraction layout is the same in either range
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      local_hi  <= 8'h00;
      local_lo  <= 8'h00;
      remote_hi <= 8'h00;
      remote_lo <= 8'h00;
    end else if (conv_state == TSR_C_RUN && conv_done) begin
      local_hi  <= local_whole;
      remote_hi <= remote_whole;
      local_lo  <= {local_frac, 4'h0} & frac_mask(local_res);
      remote_lo <= {remote_frac, 4'h0};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      range_ext    <= 1'b0;
      shutdown_bit <= 1'b0;
    end else begin
      range_ext    <= config_reg[`TSR_CFG_RANGE_BIT];
      shutdown_bit <= config_reg[`TSR_CFG_SD_BIT];
    end
  end

endmodule : tsr_slave

// ==== sim/tb_top.sv ====
// self-checking bench joining bus master and sensor slave
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [1:0] res; logic rng; logic [3:0] lf, rf; logic [7:0] el, er;} tsr_row_s;
  logic       clock, rst_n, cmd_valid, cmd_read, cmd_has_data, conv_done;
  logic [7:0] cmd_ptr, cmd_data, local_whole, remote_whole, rsp_data, rd;
  logic [3:0] local_frac, remote_frac;
  logic       cmd_ready, rsp_valid, rsp_nack, holdoff_active;
  logic       conv_start, conv_busy, range_ext, shutdown_bit;
  int         fails = 0, cmp_count = 0, starts = 0, cdown = 0, s0;
  tsr_row_s   rows [4] = '{'{2'h0, 1'b0, 4'hf, 4'h3, 8'h80, 8'h30},
                           '{2'h1, 1'b1, 4'h7, 4'hf, 8'h40, 8'hf0},
                           '{2'h2, 1'b0, 4'hb, 4'h1, 8'ha0, 8'h10},
                           '{2'h3, 1'b1, 4'h9, 4'h9, 8'h90, 8'h90}};
  tsr_if bus_if ();
  tsr_master #(.SCL_HZ(5000000), .HOLDOFF_CYCLES(50)) u_tsr_master (.clock(clock),
    .rst_n(rst_n), .bus(bus_if), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_has_data(cmd_has_data), .cmd_ptr(cmd_ptr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_data(rsp_data),
    .holdoff_active(holdoff_active));
  tsr_slave u_tsr_slave (.clock(clock), .rst_n(rst_n), .bus(bus_if),
    .local_whole(local_whole), .local_frac(local_frac), .remote_whole(remote_whole),
    .remote_frac(remote_frac), .conv_done(conv_done), .conv_start(conv_start),
    .conv_busy(conv_busy), .range_ext(range_ext), .shutdown_bit(shutdown_bit));
  tsr_link_sva u_tsr_link_sva (.clock(clock), .rst_n(rst_n), .scl_oe_host(bus_if.scl_oe_host),
    .sda_oe_host(bus_if.sda_oe_host), .sda_oe_dev(bus_if.sda_oe_dev), .scl(bus_if.scl),
    .sda(bus_if.sda));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // front end: each conversion ends 20 cycles after it starts
  always @(negedge clock) begin
    conv_done <= (cdown == 1);
    cdown     <= conv_start ? 20 : (cdown > 0 ? cdown - 1 : 0);
    starts    <= starts + int'(conv_start);
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic rdq, input logic hd, input logic [7:0] p, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clock);
    {cmd_valid, cmd_read, cmd_has_data, cmd_ptr, cmd_data} = {1'b1, rdq, hd, p, d};
    while (cmd_ready !== 1'b1 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 5000) fails++;
    rd = rsp_data;
    check({7'h0, rsp_nack}, 8'h00);
  endtask : xfer
  task automatic rdchk(input logic [7:0] p, input logic [7:0] exp);
    xfer(1'b1, 1'b0, p, 8'h00);
    check(rd, exp);
  endtask : rdchk
  task automatic report_and_stop;
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // the tests need about 25000 cycles; well beyond that means a hang
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    report_and_stop();
  end
  initial begin
    {rst_n, cmd_valid, cmd_read, cmd_has_data, cmd_ptr, cmd_data} = '0;
    {local_whole, remote_whole, local_frac, remote_frac} = '0;
    repeat (16) @(negedge clock);
    check({4'h0, bus_if.scl, bus_if.sda, cmd_ready, conv_start}, 8'h0c);
    rst_n = 1'b1;
    rdchk(8'h03, 8'h00);
    rdchk(8'h1a, 8'h03);
    foreach (rows[i]) begin
      xfer(1'b0, 1'b1, 8'h09, {5'h0, rows[i].rng, 2'h0});
      xfer(1'b0, 1'b1, 8'h1a, {6'h0, rows[i].res});
      {local_frac, remote_frac} = {rows[i].lf, rows[i].rf};
      {local_whole, remote_whole} = {4'h1, rows[i].lf, 4'h2, rows[i].rf};
      repeat (100) @(negedge clock);
      rdchk(8'h15, rows[i].el);
      rdchk(8'h10, rows[i].er);
      rdchk(8'h00, {4'h1, rows[i].lf});
      rdchk(8'h01, {4'h2, rows[i].rf});
      check({7'h0, range_ext}, {7'h0, rows[i].rng});
    end
    s0 = starts;
    repeat (200) @(negedge clock);
    check({7'h0, starts > s0 + 2}, 8'h01);
    xfer(1'b0, 1'b1, 8'h09, 8'h40);
    @(negedge clock);
    check({7'h0, holdoff_active}, 8'h01);
    repeat (60) @(negedge clock);
    s0 = starts;
    repeat (300) @(negedge clock);
    check({7'h0, conv_busy, shutdown_bit, starts == s0}, 8'h03);
    xfer(1'b0, 1'b1, 8'h0f, 8'ha5);
    xfer(1'b0, 1'b1, 8'h0f, 8'h5a);
    repeat (60) @(negedge clock);
    check(8'(starts - s0), 8'h02);
    rdchk(8'h03, 8'h40);
    xfer(1'b0, 1'b1, 8'h09, 8'h00);
    xfer(1'b0, 1'b1, 8'h0f, 8'hff);
    rdchk(8'h03, 8'h00);
    report_and_stop();
  end
endmodule : tb_top

// ==== sim/tsr_link_sva.sv ====
// wire-level checks on the link between bus master and sensor slave
`timescale 1ns/1ps
module tsr_link_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link signals
  input wire logic scl_oe_host,
  input wire logic sda_oe_host,
  input wire logic sda_oe_dev,
  input wire logic scl,
  input wire logic sda
);
  // bound holds for the bench's shortened quarter period only
  localparam int LOW_MAX = 40;
  logic [3:0] bit_cnt;
  logic       first_byte;
  // count held just before the latest scl rise: zero means that rise opened a byte boundary
  logic [3:0] cnt_at_rise;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // scl pulses since start, so the ninth pulse of the address byte is known
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bit_cnt     <= 4'h0;
      first_byte  <= 1'b0;
      cnt_at_rise <= 4'h0;
    end else if (scl && $fell(sda)) begin
      bit_cnt    <= 4'h0;
      first_byte <= 1'b1;
    end else if ($rose(scl)) begin
      cnt_at_rise <= bit_cnt;
      bit_cnt     <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      if (bit_cnt == 4'h8) first_byte <= 1'b0;
    end
  end
  reset_release_a: assert property (!$past(rst_n) |-> !scl_oe_host && !sda_oe_host && !sda_oe_dev)
    else $error("link not released after reset");
  dev_edge_low_a: assert property ($changed(sda_oe_dev) |-> !scl && !$past(scl))
    else $error("slave moved sda while scl high");
  ack_hold_a: assert property ($rose(sda_oe_dev) |-> sda_oe_dev [*8])
    else $error("slave sda drive too short");
  addr_quiet_a: assert property (scl && $fell(sda) |=> !sda_oe_dev [*8])
    else $error("slave drove sda during address");
  addr_ack_a: assert property ($rose(scl) && bit_cnt == 4'h8 && first_byte |-> sda_oe_dev)
    else $error("address byte not acknowledged");
  stop_quiet_a: assert property (scl && $rose(sda) |=> !sda_oe_dev [*8])
    else $error("slave drove sda after stop");
  host_ctrl_a: assert property (scl && $past(scl) && $changed(sda_oe_host) |-> cnt_at_rise == 4'h0)
    else $error("master moved sda in a data bit");
  clock_low_a: assert property ($fell(scl) |-> ##[1:LOW_MAX] scl)
    else $error("scl held low too long");
endmodule : tsr_link_sva
